// ===== hw/parallel_io_ports_map.svh
`ifndef PARALLEL_IO_PORTS_MAP_SVH
`define PARALLEL_IO_PORTS_MAP_SVH
`define PIO_PORT0_OFFSET 8'h80
`define PIO_PORT1_OFFSET 8'h90
`define PIO_PORT2_OFFSET 8'hA0
`define PIO_PORT3_OFFSET 8'hB0
`define PIO_PORT0_RESET  8'hFF
`define PIO_PORT1_RESET  8'hFF
`define PIO_PORT2_RESET  8'hFF
`define PIO_PORT3_RESET  8'hFF
`define PIO_PWM_A_BIT    5
`define PIO_PWM_B_BIT    6
`endif

// ===== hw/parallel_io_ports_pkg.sv
package parallel_io_ports_pkg;
   typedef enum logic [1:0] {
      RD_PIN,
      RD_LATCH,
      RD_MOD_BYTE,
      RD_MOD_BIT
   } read_kind_type;
   typedef enum logic [1:0] {
      BITOP_CLEAR,
      BITOP_SET,
      BITOP_CARRY,
      BITOP_NONE
   } bit_op_type;
endpackage : parallel_io_ports_pkg

// ===== hw/parallel_io_ports.sv
// Operation
// (RULE_01) Port zero: eight open-drain bidirectional pins governed by its latch.
// (RULE_02) Port zero carries multiplexed low address and data during external accesses.
// (RULE_03) Latch write stores bus value; latch read returns latch; pin read returns pins.
// (RULE_04) Any external memory access loads all ones into the port zero latch.
// (RULE_05) External-memory control high: port zero driven push-pull from address/data bus.
// (RULE_06) Port zero GPIO: latch one floats pin, latch zero drives low.
// (RULE_07) Port one has no output drive; pins are analog or digital inputs only.
// (RULE_08) Port one bit one selects analog input; zero selects digital input.
// (RULE_09) Port two GPIO: latch one pulled up as input, latch zero drives low.
// (RULE_10) Port two outputs middle and high address bytes during external accesses.
// (RULE_11) Pulse unit overrides port two bits five, six; bit seven is pulse clock input.
// (RULE_12) Port two bits zero to four carry SPI and timer-two alternate functions.
// (RULE_13) Port three: latch one pulled up as input, latch zero drives low.
// (RULE_14) Port three alternate output drives only when latch is one, else pin low.
// (RULE_15) Port three bits map serial, interrupts, timer inputs, write and read strobes.
// (RULE_16) An enabled peripheral takes its pin away from general-purpose use.
// (RULE_17) Read-modify-write to a port takes its source value from the latch.
// (RULE_18) Latch-reading set: logic, jump-clear, complement, increment, decrement, bit ops.
// (RULE_19) Bit writes read whole latch byte, alter one bit, write byte back.
// (RULE_20) Other port reads use the pin path, returning actual pin levels.
// (RULE_21) Reset sets port zero, two and three latches to all ones.
//
// The strobed register port was left to the implementer.
`include "parallel_io_ports_map.svh"
`timescale 1ns/10ps
`default_nettype none
module parallel_io_ports #(
   parameter int W = 8
) (
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   input  wire logic [7:0]                             addr,
   input  wire logic [7:0]                             wdata,
   input  wire logic                                   wr_stb,
   input  wire logic                                   rd_stb,
   input  wire parallel_io_ports_pkg::read_kind_type   rd_kind,
   input  wire parallel_io_ports_pkg::bit_op_type      bit_op,
   input  wire logic [2:0]                             bit_sel,
   input  wire logic                                   carry_in,
   output logic [7:0]                                  rdata,
   input  wire logic                                   ext_mem_active,
   input  wire logic [23:0]                            ext_addr,
   input  wire logic [7:0]                             ext_wdata,
   input  wire logic                                   ext_data_phase,
   input  wire logic                                   ext_drive_data,
   input  wire logic                                   ext_wr_strobe_n,
   input  wire logic                                   ext_rd_strobe_n,
   output logic [7:0]                                  ext_rdata,
   input  wire logic [W-1:0]                           port0_in,
   output logic [W-1:0]                                port0_out,
   output logic [W-1:0]                                port0_oe,
   input  wire logic [W-1:0]                           port1_in,
   output logic [W-1:0]                                port1_analog_sel,
   output logic [W-1:0]                                port1_digital,
   input  wire logic [W-1:0]                           port2_in,
   output logic [W-1:0]                                port2_out,
   output logic [W-1:0]                                port2_oe,
   input  wire logic [W-1:0]                           port3_in,
   output logic [W-1:0]                                port3_out,
   output logic [W-1:0]                                port3_oe,
   input  wire logic                                   pulse_a_en,
   input  wire logic                                   pulse_b_en,
   input  wire logic                                   pulse_out_a,
   input  wire logic                                   pulse_out_b,
   output logic                                        pulse_unit_clock_in,
   input  wire logic                                   spi_en,
   input  wire logic                                   spi_clk_out,
   input  wire logic                                   spi_clk_oe,
   input  wire logic                                   spi_mosi_out,
   input  wire logic                                   spi_mosi_oe,
   input  wire logic                                   spi_miso_out,
   input  wire logic                                   spi_miso_oe,
   output logic                                        serial_peripheral_clock_pin,
   output logic                                        spi_mosi_in,
   output logic                                        spi_miso_in,
   output logic                                        spi_ss_in,
   output logic                                        timer_two_clk_in,
   output logic                                        timer_two_ext_control,
   input  wire logic                                   uart_en,
   input  wire logic                                   uart_txd,
   input  wire logic                                   uart_rxd_out,
   input  wire logic                                   uart_rxd_oe,
   output logic                                        uart_rxd,
   output logic                                        ext_irq_a,
   output logic                                        ext_irq_b,
   output logic                                        timer_zero_count_in,
   output logic                                        timer_one_count_in
);
   logic [1:0]   rst_sync_q;
   logic         rst_core_n;
   logic [W-1:0] p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q;
   logic [W-1:0] p2_s1_q, p2_s2_q, p3_s1_q, p3_s2_q;
   logic [W-1:0] port_zero_latch_q, port_one_config_q, port_two_latch_q, port_three_latch_q;
   logic [W-1:0] sel_latch, sel_pin, mod_byte;
   logic         hit0, hit1, hit2, hit3;
   logic [W-1:0] p3_alt_val, p3_alt_en;

   function automatic logic [W-1:0] set_bit(input logic [W-1:0] b, input logic [2:0] i, input logic v);
      logic [W-1:0] r;
      r = b;
      r[i] = v;
      return r;
   endfunction : set_bit

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_core_n = rst_sync_q[1];

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         p0_s1_q <= '0;
         p0_s2_q <= '0;
         p1_s1_q <= '0;
         p1_s2_q <= '0;
         p2_s1_q <= '0;
         p2_s2_q <= '0;
         p3_s1_q <= '0;
         p3_s2_q <= '0;
      end else begin
         p0_s1_q <= port0_in;
         p0_s2_q <= p0_s1_q;
         p1_s1_q <= port1_in;
         p1_s2_q <= p1_s1_q;
         p2_s1_q <= port2_in;
         p2_s2_q <= p2_s1_q;
         p3_s1_q <= port3_in;
         p3_s2_q <= p3_s1_q;
      end
   end

   assign hit0 = (addr == `PIO_PORT0_OFFSET);
   assign hit1 = (addr == `PIO_PORT1_OFFSET);
   assign hit2 = (addr == `PIO_PORT2_OFFSET);
   assign hit3 = (addr == `PIO_PORT3_OFFSET);

   always_comb begin
      sel_latch = '0;
      sel_pin   = '0;
      if (hit0) begin
         sel_latch = port_zero_latch_q;
         sel_pin   = p0_s2_q;
      end else if (hit1) begin
         sel_latch = port_one_config_q;
         sel_pin   = p1_s2_q;
      end else if (hit2) begin
         sel_latch = port_two_latch_q;
         sel_pin   = p2_s2_q;
      end else if (hit3) begin
         sel_latch = port_three_latch_q;
         sel_pin   = p3_s2_q;
      end
   end

   // Byte written back: plain write, or single-bit modify of the latch
   always_comb begin
      unique case (bit_op)
         parallel_io_ports_pkg::BITOP_CLEAR: mod_byte = set_bit(sel_latch, bit_sel, 1'b0);    // RULE_19
         parallel_io_ports_pkg::BITOP_SET:   mod_byte = set_bit(sel_latch, bit_sel, 1'b1);    // RULE_19
         parallel_io_ports_pkg::BITOP_CARRY: mod_byte = set_bit(sel_latch, bit_sel, carry_in); // RULE_19
         parallel_io_ports_pkg::BITOP_NONE:  mod_byte = wdata;
      endcase
   end

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         port_zero_latch_q <= `PIO_PORT0_RESET; // RULE_21
      end else if (ext_mem_active) begin
         port_zero_latch_q <= '1; // RULE_04
      end else if (wr_stb && hit0) begin
         port_zero_latch_q <= mod_byte; // RULE_03
      end
   end

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         port_one_config_q <= `PIO_PORT1_RESET; // RULE_08
      end else if (wr_stb && hit1) begin
         port_one_config_q <= mod_byte;
      end
   end

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         port_two_latch_q <= `PIO_PORT2_RESET; // RULE_21
      end else if (wr_stb && hit2) begin
         port_two_latch_q <= mod_byte;
      end
   end

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         port_three_latch_q <= `PIO_PORT3_RESET; // RULE_21
      end else if (wr_stb && hit3) begin
         port_three_latch_q <= mod_byte;
      end
   end

   // Latch and modify reads use the latch, pin reads the synchronised pins
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         unique case (rd_kind)
            parallel_io_ports_pkg::RD_LATCH,
            parallel_io_ports_pkg::RD_MOD_BYTE,
            parallel_io_ports_pkg::RD_MOD_BIT: rdata <= sel_latch; // RULE_17 RULE_18
            parallel_io_ports_pkg::RD_PIN:     rdata <= sel_pin;   // RULE_20 RULE_03
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ext_rdata <= 8'h00;
      end else if (ext_mem_active && ext_data_phase) begin
         ext_rdata <= p0_s2_q; // RULE_02
      end
   end

   // Port zero: bus push-pull, else open drain from latch
   always_comb begin
      if (ext_mem_active) begin
         port0_out = ext_data_phase ? ext_wdata : ext_addr[7:0]; // RULE_02 RULE_05
         port0_oe  = (ext_data_phase && !ext_drive_data) ? '0 : '1; // RULE_05
      end else begin
         port0_out = '0;                  // RULE_01 RULE_06
         port0_oe  = ~port_zero_latch_q;  // RULE_06
      end
   end

   assign port1_analog_sel = port_one_config_q;  // RULE_07 RULE_08
   assign port1_digital    = p1_s2_q & ~port_one_config_q;

   // Port two: address bytes, pulse outputs, SPI, else pulled-up GPIO
   always_comb begin
      port2_out = '0;
      port2_oe  = ~port_two_latch_q; // RULE_09
      if (ext_mem_active) begin
         port2_out = ext_data_phase ? ext_addr[23:16] : ext_addr[15:8]; // RULE_10
         port2_oe  = '1;
      end else begin
         if (spi_en) begin
            port2_out[0] = spi_clk_out;  // RULE_12 RULE_16
            port2_oe[0]  = spi_clk_oe;
            port2_out[1] = spi_mosi_out; // RULE_12
            port2_oe[1]  = spi_mosi_oe;
            port2_out[2] = spi_miso_out; // RULE_12
            port2_oe[2]  = spi_miso_oe;
         end
         if (pulse_a_en) begin
            port2_out[`PIO_PWM_A_BIT] = pulse_out_a; // RULE_11 RULE_16
            port2_oe[`PIO_PWM_A_BIT]  = 1'b1;
         end
         if (pulse_b_en) begin
            port2_out[`PIO_PWM_B_BIT] = pulse_out_b; // RULE_11
            port2_oe[`PIO_PWM_B_BIT]  = 1'b1;
         end
      end
   end

   assign serial_peripheral_clock_pin = p2_s2_q[0]; // RULE_12
   assign spi_mosi_in           = p2_s2_q[1];
   assign spi_miso_in           = p2_s2_q[2];
   assign spi_ss_in             = p2_s2_q[3];
   assign timer_two_clk_in      = p2_s2_q[3];
   assign timer_two_ext_control = p2_s2_q[4];
   assign pulse_unit_clock_in   = p2_s2_q[7]; // RULE_11

   // Port three alternate outputs gated by a latched one
   always_comb begin
      p3_alt_val = '1;
      p3_alt_en  = '0;
      if (uart_en) begin
         p3_alt_val[0] = uart_rxd_out; // RULE_15 RULE_16
         p3_alt_en[0]  = uart_rxd_oe;
         p3_alt_val[1] = uart_txd;     // RULE_15
         p3_alt_en[1]  = 1'b1;
      end
      if (ext_mem_active) begin
         p3_alt_val[6] = ext_wr_strobe_n; // RULE_15
         p3_alt_en[6]  = 1'b1;
         p3_alt_val[7] = ext_rd_strobe_n; // RULE_15
         p3_alt_en[7]  = 1'b1;
      end
   end

   assign port3_out = port_three_latch_q & p3_alt_val;                      // RULE_14
   assign port3_oe  = ~port_three_latch_q | (p3_alt_en & port_three_latch_q); // RULE_13 RULE_14

   assign uart_rxd            = p3_s2_q[0];
   assign ext_irq_a           = p3_s2_q[2]; // RULE_15
   assign ext_irq_b           = p3_s2_q[3];
   assign timer_zero_count_in = p3_s2_q[4];
   assign timer_one_count_in  = p3_s2_q[5];

   property p_ext_ones;
      @(posedge clk) disable iff (!rst_core_n)
      ext_mem_active |=> (port_zero_latch_q == 8'hFF);
   endproperty
   a_ext_ones: assert property (p_ext_ones) else $error("port zero latch not all ones"); // RULE_04

   property p_p0_pushpull;
      @(posedge clk) disable iff (!rst_core_n)
      (ext_mem_active && !ext_data_phase) |-> (port0_oe == 8'hFF && port0_out == ext_addr[7:0]);
   endproperty
   a_p0_pushpull: assert property (p_p0_pushpull) else $error("port zero not driving address"); // RULE_05

   property p_p0_opendrain;
      @(posedge clk) disable iff (!rst_core_n)
      !ext_mem_active |-> (port0_out == 8'h00 && port0_oe == ~port_zero_latch_q);
   endproperty
   a_p0_opendrain: assert property (p_p0_opendrain) else $error("port zero open drain wrong"); // RULE_06

   property p_latch_write;
      @(posedge clk) disable iff (!rst_core_n)
      (wr_stb && hit2 && bit_op == parallel_io_ports_pkg::BITOP_NONE) |=> (port_two_latch_q == $past(wdata));
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // RULE_03

   sequence s_latch_rd;
      rd_stb && rd_kind != parallel_io_ports_pkg::RD_PIN;
   endsequence
   property p_latch_read;
      @(posedge clk) disable iff (!rst_core_n)
      s_latch_rd |=> (rdata == $past(sel_latch));
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("modify read not from latch"); // RULE_17

   property p_pin_read;
      @(posedge clk) disable iff (!rst_core_n)
      (rd_stb && rd_kind == parallel_io_ports_pkg::RD_PIN) |=> (rdata == $past(sel_pin));
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin read wrong"); // RULE_20

   property p_bit_set;
      @(posedge clk) disable iff (!rst_core_n)
      (wr_stb && hit3 && bit_op == parallel_io_ports_pkg::BITOP_SET)
         |=> (port_three_latch_q == ($past(port_three_latch_q) | (8'h01 << $past(bit_sel))));
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set altered other bits"); // RULE_19

   property p_p3_low;
      @(posedge clk) disable iff (!rst_core_n)
      (port_three_latch_q[1] == 1'b0) |-> (port3_oe[1] && !port3_out[1]);
   endproperty
   a_p3_low: assert property (p_p3_low) else $error("port three pin not low"); // RULE_14

   property p_pulse_a;
      @(posedge clk) disable iff (!rst_core_n)
      (pulse_a_en && !ext_mem_active) |-> (port2_oe[5] && port2_out[5] == pulse_out_a);
   endproperty
   a_pulse_a: assert property (p_pulse_a) else $error("pulse output not on pin"); // RULE_11

   property p_p2_addr;
      @(posedge clk) disable iff (!rst_core_n)
      ext_mem_active |-> (port2_oe == 8'hFF && port2_out == (ext_data_phase ? ext_addr[23:16] : ext_addr[15:8]));
   endproperty
   a_p2_addr: assert property (p_p2_addr) else $error("port two address byte wrong"); // RULE_10

   property p_ext_rdata;
      @(posedge clk) disable iff (!rst_core_n)
      (ext_mem_active && ext_data_phase) |=> (ext_rdata == $past(p0_s2_q));
   endproperty
   a_ext_rdata: assert property (p_ext_rdata) else $error("external read data not captured"); // RULE_02
endmodule : parallel_io_ports
`default_nettype wire

// ===== verification/pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   input  wire logic [7:0] port0_out,
   input  wire logic [7:0] port0_oe,
   input  wire logic [7:0] port2_out,
   input  wire logic [7:0] port2_oe,
   input  wire logic [7:0] port3_out,
   input  wire logic [7:0] port3_oe,
   input  wire logic [7:0] drv0_en,
   input  wire logic [7:0] drv0_val,
   input  wire logic [7:0] drv1_val,
   input  wire logic [7:0] drv2_en,
   input  wire logic [7:0] drv2_val,
   input  wire logic [7:0] drv3_en,
   input  wire logic [7:0] drv3_val,
   output logic [7:0]      port0_in,
   output logic [7:0]      port1_in,
   output logic [7:0]      port2_in,
   output logic [7:0]      port3_in
);
   // Undriven lines sit at the pull-up level; port zero's is a board resistor
   assign port0_in = (port0_oe & port0_out) | (~port0_oe & ((drv0_en & drv0_val) | ~drv0_en));
   assign port1_in = drv1_val;
   assign port2_in = (port2_oe & port2_out) | (~port2_oe & ((drv2_en & drv2_val) | ~drv2_en));
   assign port3_in = (port3_oe & port3_out) | (~port3_oe & ((drv3_en & drv3_val) | ~drv3_en));
endmodule : pin_partner
`default_nettype wire

// ===== verification/testbench.sv
`include "parallel_io_ports_map.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk, rst_n, wr_stb, rd_stb, carry_in, ext_mem_active, ext_data_phase, ext_drive_data;
   logic ext_wr_strobe_n, ext_rd_strobe_n, pulse_a_en, pulse_b_en, pulse_out_a, pulse_out_b;
   logic spi_en, spi_clk_out, spi_clk_oe, spi_mosi_out, spi_mosi_oe, spi_miso_out, spi_miso_oe;
   logic uart_en, uart_txd, uart_rxd_out, uart_rxd_oe, pulse_unit_clock_in, serial_peripheral_clock_pin;
   logic spi_mosi_in, spi_miso_in, spi_ss_in, timer_two_clk_in, timer_two_ext_control, uart_rxd;
   logic ext_irq_a, ext_irq_b, timer_zero_count_in, timer_one_count_in;
   logic [7:0] addr, wdata, ext_wdata, rdata, ext_rdata, d;
   logic [2:0] bit_sel;
   logic [23:0] ext_addr;
   logic [7:0] port0_in, port0_out, port0_oe, port1_in, port1_analog_sel, port1_digital;
   logic [7:0] port2_in, port2_out, port2_oe, port3_in, port3_out, port3_oe;
   logic [7:0] drv0_en, drv0_val, drv1_val, drv2_en, drv2_val, drv3_en, drv3_val;
   parallel_io_ports_pkg::read_kind_type rd_kind;
   parallel_io_ports_pkg::bit_op_type    bit_op;
   int fail_count, tests_run, cycles;

   parallel_io_ports DUT (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rd_kind, .bit_op, .bit_sel, .carry_in,
      .rdata, .ext_mem_active, .ext_addr, .ext_wdata, .ext_data_phase, .ext_drive_data, .ext_wr_strobe_n,
      .ext_rd_strobe_n, .ext_rdata, .port0_in, .port0_out, .port0_oe, .port1_in, .port1_analog_sel,
      .port1_digital, .port2_in, .port2_out, .port2_oe, .port3_in, .port3_out, .port3_oe, .pulse_a_en,
      .pulse_b_en, .pulse_out_a, .pulse_out_b, .pulse_unit_clock_in, .spi_en, .spi_clk_out, .spi_clk_oe,
      .spi_mosi_out, .spi_mosi_oe, .spi_miso_out, .spi_miso_oe, .serial_peripheral_clock_pin, .spi_mosi_in,
      .spi_miso_in, .spi_ss_in, .timer_two_clk_in, .timer_two_ext_control, .uart_en, .uart_txd, .uart_rxd_out,
      .uart_rxd_oe, .uart_rxd, .ext_irq_a, .ext_irq_b, .timer_zero_count_in, .timer_one_count_in);
   pin_partner u_pins (.port0_out, .port0_oe, .port2_out, .port2_oe, .port3_out, .port3_oe, .drv0_en, .drv0_val,
      .drv1_val, .drv2_en, .drv2_val, .drv3_en, .drv3_val, .port0_in, .port1_in, .port2_in, .port3_in);

   always #4 clk = ~clk;

   task automatic summarize;
      $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input parallel_io_ports_pkg::bit_op_type op,
                     input logic [2:0] b, input logic c);
      @(posedge clk);
      addr     <= a;
      wdata    <= v;
      bit_op   <= op;
      bit_sel  <= b;
      carry_in <= c;
      wr_stb   <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input parallel_io_ports_pkg::read_kind_type k, output logic [7:0] v);
      @(posedge clk);
      addr    <= a;
      rd_kind <= k;
      rd_stb  <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   task automatic t_reset;
      logic [7:0] offs [4];
      offs = '{`PIO_PORT0_OFFSET, `PIO_PORT1_OFFSET, `PIO_PORT2_OFFSET, `PIO_PORT3_OFFSET};
      foreach (offs[i]) begin
         rd(offs[i], parallel_io_ports_pkg::RD_LATCH, d);
         check(d, 8'hFF);
      end
      check(port1_analog_sel, 8'hFF);
      check(port0_oe, 8'h00);
      check({7'h00, timer_two_clk_in}, 8'h01);
      $display("test reset done");
   endtask : t_reset

   task automatic t_latch;
      wr(`PIO_PORT2_OFFSET, 8'h55, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      check(port2_oe, 8'hAA);
      check(port2_in, 8'h55);
      rd(`PIO_PORT2_OFFSET, parallel_io_ports_pkg::RD_LATCH, d);
      check(d, 8'h55);
      $display("test latch done");
   endtask : t_latch

   task automatic t_port0;
      wr(`PIO_PORT0_OFFSET, 8'h0F, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      check(port0_oe, 8'hF0);
      check(port0_out & port0_oe, 8'h00);
      drv0_en <= 8'h01;
      idle(3);
      rd(`PIO_PORT0_OFFSET, parallel_io_ports_pkg::RD_PIN, d);
      check(d, 8'h0E);
      rd(`PIO_PORT0_OFFSET, parallel_io_ports_pkg::RD_MOD_BYTE, d);
      check(d, 8'h0F);
      rd(`PIO_PORT0_OFFSET, parallel_io_ports_pkg::RD_MOD_BIT, d);
      check(d, 8'h0F);
      drv0_en <= 8'h00;
      $display("test port0 done");
   endtask : t_port0

   task automatic t_bitops;
      parallel_io_ports_pkg::bit_op_type ops [4];
      logic [2:0] bits [4];
      logic [7:0] exp [4];
      ops  = '{parallel_io_ports_pkg::BITOP_SET, parallel_io_ports_pkg::BITOP_CLEAR,
               parallel_io_ports_pkg::BITOP_CARRY, parallel_io_ports_pkg::BITOP_CARRY};
      bits = '{3'h1, 3'h7, 3'h4, 3'h0};
      exp  = '{8'hA7, 8'h27, 8'h37, 8'h36};
      wr(`PIO_PORT3_OFFSET, 8'hA5, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      foreach (ops[i]) begin
         wr(`PIO_PORT3_OFFSET, 8'h00, ops[i], bits[i], (i == 2) ? 1'b1 : 1'b0);
         rd(`PIO_PORT3_OFFSET, parallel_io_ports_pkg::RD_LATCH, d);
         check(d, exp[i]);
      end
      check(port3_in, 8'h36);
      wr(`PIO_PORT3_OFFSET, 8'hFF, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      $display("test bitops done");
   endtask : t_bitops

   task automatic t_port1;
      wr(`PIO_PORT1_OFFSET, 8'h0F, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      check(port1_analog_sel, 8'h0F);
      drv1_val <= 8'h3C;
      idle(3);
      check(port1_digital, 8'h30);
      rd(`PIO_PORT1_OFFSET, parallel_io_ports_pkg::RD_PIN, d);
      check(d, 8'h3C);
      $display("test port1 done");
   endtask : t_port1

   task automatic t_ext;
      wr(`PIO_PORT0_OFFSET, 8'h00, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      @(posedge clk);
      ext_mem_active  <= 1'b1;
      ext_addr        <= 24'h5A3C96;
      ext_wr_strobe_n <= 1'b0;
      idle(1);
      check(port0_oe, 8'hFF);
      check(port0_out, 8'h96);
      check(port2_out, 8'h3C);
      check({6'h00, port3_in[7:6]}, 8'h02);
      @(posedge clk);
      ext_data_phase <= 1'b1;
      ext_drive_data <= 1'b1;
      ext_wdata      <= 8'hE1;
      idle(1);
      check(port0_out, 8'hE1);
      check(port2_out, 8'h5A);
      @(posedge clk);
      ext_drive_data  <= 1'b0;
      ext_wr_strobe_n <= 1'b1;
      ext_rd_strobe_n <= 1'b0;
      drv0_en         <= 8'hFF;
      drv0_val        <= 8'hC3;
      idle(4);
      check(port0_oe, 8'h00);
      check(ext_rdata, 8'hC3);
      check({6'h00, port3_in[7:6]}, 8'h01);
      @(posedge clk);
      ext_mem_active  <= 1'b0;
      ext_rd_strobe_n <= 1'b1;
      drv0_en         <= 8'h00;
      rd(`PIO_PORT0_OFFSET, parallel_io_ports_pkg::RD_LATCH, d);
      check(d, 8'hFF);
      $display("test external memory done");
   endtask : t_ext

   task automatic t_alt;
      wr(`PIO_PORT3_OFFSET, 8'hFD, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      @(posedge clk);
      uart_en  <= 1'b1;
      uart_txd <= 1'b1;
      idle(1);
      check({7'h00, port3_in[1]}, 8'h00);
      wr(`PIO_PORT3_OFFSET, 8'hFF, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      check({7'h00, port3_in[1]}, 8'h01);
      @(posedge clk);
      uart_txd <= 1'b0;
      idle(1);
      check({7'h00, port3_in[1]}, 8'h00);
      wr(`PIO_PORT2_OFFSET, 8'h00, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      @(posedge clk);
      pulse_a_en  <= 1'b1;
      pulse_out_a <= 1'b1;
      pulse_b_en  <= 1'b1;
      pulse_out_b <= 1'b1;
      spi_en      <= 1'b1;
      spi_clk_out <= 1'b1;
      spi_clk_oe  <= 1'b1;
      spi_mosi_oe <= 1'b1;
      idle(1);
      check(port2_in, 8'h65);
      check(port2_oe, 8'hFB);
      @(posedge clk);
      pulse_a_en <= 1'b0;
      pulse_b_en <= 1'b0;
      spi_en     <= 1'b0;
      uart_en    <= 1'b0;
      wr(`PIO_PORT2_OFFSET, 8'hFF, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      drv2_en  <= 8'h9F;
      drv2_val <= 8'h95;
      drv3_en  <= 8'h3D;
      drv3_val <= 8'h14;
      idle(3);
      check({pulse_unit_clock_in, 2'b00, timer_two_ext_control, spi_ss_in, spi_miso_in, spi_mosi_in,
             serial_peripheral_clock_pin}, 8'h95);
      check({2'b00, timer_one_count_in, timer_zero_count_in, ext_irq_b, ext_irq_a, 1'b0, uart_rxd}, 8'h14);
      $display("test alternate functions done");
   endtask : t_alt

   task automatic t_unmapped;
      wr(8'h81, 8'h00, parallel_io_ports_pkg::BITOP_NONE, 3'h0, 1'b0);
      rd(8'h81, parallel_io_ports_pkg::RD_LATCH, d);
      check(d, 8'h00);
      rd(`PIO_PORT0_OFFSET, parallel_io_ports_pkg::RD_LATCH, d);
      check(d, 8'hFF);
      $display("test unmapped done");
   endtask : t_unmapped

   initial begin
      {clk, rst_n, wr_stb, rd_stb, carry_in, ext_mem_active, ext_data_phase, ext_drive_data} = '0;
      {pulse_a_en, pulse_b_en, pulse_out_a, pulse_out_b, uart_en, uart_txd, uart_rxd_out, uart_rxd_oe} = '0;
      {spi_en, spi_clk_out, spi_clk_oe, spi_mosi_out, spi_mosi_oe, spi_miso_out, spi_miso_oe} = '0;
      {ext_wr_strobe_n, ext_rd_strobe_n} = 2'b11;
      {addr, wdata, ext_wdata, bit_sel, ext_addr} = '0;
      {drv0_en, drv0_val, drv1_val, drv2_en, drv2_val, drv3_en, drv3_val} = '0;
      rd_kind = parallel_io_ports_pkg::RD_LATCH;
      bit_op  = parallel_io_ports_pkg::BITOP_NONE;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_latch();
      t_port0();
      t_bitops();
      t_port1();
      t_ext();
      t_alt();
      t_unmapped();
      summarize();
   end
endmodule : testbench
`default_nettype wire
